/* File: rtl/sar_converter_control.sv */
// Control logic of a 10-bit successive-approximation converter with a 16-way input mux.
//
// Function
// - Route one of 16 analog inputs chosen by the 4-bit channel_select field.
// - Each conversion is a sampling phase then successive approximation to 10 bits.
// - Each completed 10-bit result is placed in the readable result registers.
// - With converter_on set, convert the selected channel continuously until cleared.
// - Set the done flag when a conversion ends and its result is stored.
// - Clear the done flag on a result_high read or any control write.
// - Results are not latched; each conversion overwrites both result registers.
// - A new channel selection aborts the conversion, clears done, restarts.
// - Input above the high reference gives full scale, FFh and 03h, no overflow.
// - Input below the low reference gives zero in both result registers.
// - Clearing converter_on disables the converter to save power.
// - Wait low-power mode has no effect on conversion.
// - Halt disables the converter; software waits stabilization_time after wake-up.
// - Analog use of a pin does not stop its digital level being read.
// - Converter clock is cpu_clock divided by 4, or by 2 when speed set.
// - result_high holds result bits 9 down to 2.
// - result_low holds result bits 1 and 0; bits 7 to 2 read zero.
`timescale 1ns/1ps
module sar_converter_control #(
  parameter int SAMPLE_CYC = sar_pkg::SAMPLE_TICKS,
  parameter int CHANNELS = sar_pkg::NUM_CH
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic csr_wr,
  input wire logic [7:0] csr_wdata,
  input wire logic result_high_rd,
  input wire logic halt_mode,
  input wire logic comp_in,
  input wire logic [CHANNELS-1:0] pin_level,
  output logic [7:0] converter_control_status,
  output logic [7:0] result_high,
  output logic [7:0] result_low,
  output logic [3:0] channel_select,
  output logic converter_power,
  output logic converter_clock,
  output logic sample_hold,
  output logic [9:0] dac_code,
  output logic [CHANNELS-1:0] port_level
);
  // ==========================================================================
  // Declarations
  // ==========================================================================
  localparam int CW = $clog2(SAMPLE_CYC + 1);
  localparam int CONV_TICKS = SAMPLE_CYC + 2 * sar_pkg::RES_BITS;
  localparam logic [9:0] ONE = 10'h001;
  localparam logic [9:0] MSB = 10'h200;
  sar_pkg::sar_state_type st_q;
  logic eoc_q;
  logic speed_q;
  logic on_q;
  logic [3:0] ch_q;
  logic [9:0] res_q;
  logic [9:0] dac_q;
  logic [3:0] bit_q;
  logic phase_q;
  logic [CW-1:0] cnt_q;
  logic [1:0] div_q;
  logic clk_out_q;
  logic power_q;
  logic sh_q;
  logic comp_s1_q;
  logic comp_s2_q;
  logic [CHANNELS-1:0] pin_s1_q;
  logic [CHANNELS-1:0] pin_s2_q;
  logic on_next_w;
  logic run_w;
  logic chan_chg_w;
  logic tick_w;
  logic [1:0] lim_w;
  logic [9:0] onehot_w;
  logic [9:0] keep_w;
  logic done_w;
  logic [7:0] ticks_q;
  logic all_hi_q;
  logic all_lo_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      comp_s1_q <= 1'b0;
      comp_s2_q <= 1'b0;
    end else begin
      comp_s1_q <= comp_in;
      comp_s2_q <= comp_s1_q;
    end
  end

  // Pin levels stay readable as logic inputs whatever the mux selects.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_level;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ==========================================================================
  // Control and status
  // ==========================================================================
  assign on_next_w = csr_wr ? csr_wdata[sar_pkg::CSR_ON] : on_q;
  // Besides converter_on, only halt gates the converter; wait mode is deliberately not an input.
  assign run_w = on_next_w && !halt_mode;
  assign chan_chg_w = csr_wr && (csr_wdata[sar_pkg::CSR_CH_LSB +: sar_pkg::CSR_CH_W] != ch_q);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      speed_q <= sar_pkg::CSR_RESET[sar_pkg::CSR_SPEED];
      on_q <= sar_pkg::CSR_RESET[sar_pkg::CSR_ON];
      ch_q <= sar_pkg::CSR_RESET[sar_pkg::CSR_CH_LSB +: sar_pkg::CSR_CH_W];
    end else if (csr_wr) begin
      speed_q <= csr_wdata[sar_pkg::CSR_SPEED];
      on_q <= csr_wdata[sar_pkg::CSR_ON];
      ch_q <= csr_wdata[sar_pkg::CSR_CH_LSB +: sar_pkg::CSR_CH_W];
    end
  end

  // A completion in the same cycle as a clear keeps the flag set.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      eoc_q <= sar_pkg::CSR_RESET[sar_pkg::CSR_EOC];
    end else if (done_w) begin
      eoc_q <= 1'b1;
    end else if (csr_wr || result_high_rd) begin
      eoc_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Converter clock divider
  // ==========================================================================
  assign lim_w = speed_q ? 2'(sar_pkg::DIV_FAST - 1) : 2'(sar_pkg::DIV_SLOW - 1);
  assign tick_w = div_q >= lim_w;

  always_ff @(posedge ref_clk) begin
    if (!rstn || !run_w) begin
      div_q <= 2'h0;
      clk_out_q <= 1'b0;
    end else begin
      div_q <= tick_w ? 2'h0 : div_q + 2'h1;
      clk_out_q <= tick_w ? 1'b0 : (div_q >= (lim_w >> 1));
    end
  end

  // ==========================================================================
  // Successive approximation sequencer
  // ==========================================================================
  assign onehot_w = ONE << bit_q;
  assign keep_w = comp_s2_q ? dac_q : (dac_q & ~onehot_w);
  assign done_w = run_w && !chan_chg_w && st_q == sar_pkg::ST_CONVERT && tick_w && phase_q
                  && bit_q == 4'h0;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st_q <= sar_pkg::ST_IDLE;
      cnt_q <= '0;
      bit_q <= 4'h0;
      phase_q <= 1'b0;
      dac_q <= sar_pkg::RES_RESET;
    end else if (!run_w) begin
      st_q <= sar_pkg::ST_IDLE;
      dac_q <= sar_pkg::RES_RESET;
    end else if (chan_chg_w || st_q == sar_pkg::ST_IDLE) begin
      st_q <= sar_pkg::ST_SAMPLE;
      cnt_q <= '0;
      phase_q <= 1'b0;
      dac_q <= sar_pkg::RES_RESET;
    end else if (tick_w) begin
      case (st_q)
        sar_pkg::ST_SAMPLE: begin
          if (cnt_q == CW'(SAMPLE_CYC - 1)) begin
            st_q <= sar_pkg::ST_CONVERT;
            bit_q <= 4'(sar_pkg::RES_BITS - 1);
            phase_q <= 1'b0;
            dac_q <= MSB;
          end else begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
        sar_pkg::ST_CONVERT: begin
          phase_q <= !phase_q;
          if (phase_q) begin
            if (bit_q == 4'h0) begin
              st_q <= sar_pkg::ST_SAMPLE;
              cnt_q <= '0;
              dac_q <= sar_pkg::RES_RESET;
            end else begin
              bit_q <= bit_q - 4'h1;
              dac_q <= keep_w | (onehot_w >> 1);
            end
          end
        end
        default: begin
          st_q <= sar_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // A comparator held high or low for every step yields full scale or zero.
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      res_q <= sar_pkg::RES_RESET;
    end else if (done_w) begin
      res_q <= keep_w;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      power_q <= 1'b0;
      sh_q <= 1'b0;
    end else begin
      power_q <= run_w;
      sh_q <= run_w && st_q == sar_pkg::ST_SAMPLE;
    end
  end

  // ==========================================================================
  // Outputs; completion is polled only, there is no interrupt request
  // ==========================================================================
  assign converter_control_status = {eoc_q, speed_q, on_q, 1'b0, ch_q};
  assign result_high = res_q[9:sar_pkg::RES_HIGH_LSB];
  assign result_low = {6'h00, res_q[sar_pkg::RES_HIGH_LSB-1:0]};
  assign channel_select = ch_q;
  assign converter_power = power_q;
  assign converter_clock = clk_out_q;
  assign sample_hold = sh_q;
  assign dac_code = dac_q;
  assign port_level = pin_s2_q;

  // ==========================================================================
  // Checking helpers and assertions
  // ==========================================================================
  always_ff @(posedge ref_clk) begin
    if (!rstn || st_q == sar_pkg::ST_IDLE || chan_chg_w || done_w) begin
      ticks_q <= 8'h00;
      all_hi_q <= 1'b1;
      all_lo_q <= 1'b1;
    end else if (tick_w) begin
      ticks_q <= ticks_q + 8'h01;
      if (st_q == sar_pkg::ST_CONVERT && phase_q) begin
        all_hi_q <= all_hi_q && comp_s2_q;
        all_lo_q <= all_lo_q && !comp_s2_q;
      end
    end
  end

  sequence chan_write_s;
    csr_wr && chan_chg_w && csr_wdata[sar_pkg::CSR_ON] && !halt_mode;
  endsequence

  sequence restart_s;
    st_q == sar_pkg::ST_SAMPLE && !eoc_q && cnt_q == '0;
  endsequence

  eoc_set_a: assert property (done_w |=> eoc_q && res_q == $past(keep_w))
    else $error("done flag or result not updated on completion");
  eoc_read_clr_a: assert property (result_high_rd && !done_w |=> !eoc_q)
    else $error("result_high read did not clear the done flag");
  eoc_write_clr_a: assert property (csr_wr && !done_w |=>
                                    !eoc_q ##1 !eoc_q || $past(done_w))
    else $error("control write did not clear the done flag");
  chan_abort_a: assert property (chan_write_s |=> restart_s)
    else $error("channel change did not restart the conversion");
  div_slow_a: assert property (tick_w && !speed_q && run_w && !csr_wr |=>
                               (!tick_w || speed_q) [*3])
    else $error("slow converter clock is not a divide by four");
  div_fast_a: assert property (tick_w && speed_q && run_w ##1 run_w && !csr_wr |->
                               !tick_w)
    else $error("fast converter clock is not a divide by two");
  conv_len_a: assert property (done_w |-> ticks_q == 8'(CONV_TICKS - 1))
    else $error("conversion length differs from the fixed tick count");
  continuous_a: assert property (done_w |=> st_q == sar_pkg::ST_SAMPLE)
    else $error("conversion did not restart after completion");
  full_scale_a: assert property (done_w && all_hi_q && comp_s2_q |=>
                                 res_q == sar_pkg::RES_FULL)
    else $error("over-range input did not give full scale");
  zero_scale_a: assert property (done_w && all_lo_q && !comp_s2_q |=>
                                 res_q == sar_pkg::RES_ZERO)
    else $error("under-range input did not give zero");
  off_power_a: assert property (csr_wr && !csr_wdata[sar_pkg::CSR_ON] |=>
                                !converter_power && st_q == sar_pkg::ST_IDLE)
    else $error("clearing converter_on did not power down");
  halt_off_a: assert property (halt_mode |=>
                               !converter_power && st_q == sar_pkg::ST_IDLE)
    else $error("halt mode did not disable the converter");
  clk_idle_a: assert property (!run_w |=> !converter_clock && dac_code == sar_pkg::RES_RESET)
    else $error("stopped converter still clocks or holds a trial code");
  sample_hold_a: assert property (chan_write_s ##1 run_w |=> sample_hold)
    else $error("restart did not raise the sample-and-hold output");
endmodule

/* File: rtl/sar_pkg.sv */
// Shared constants for the successive-approximation converter control block.
package sar_pkg;
  // ==========================================================================
  // Control and status bit layout
  // ==========================================================================
  localparam int CSR_CH_LSB = 0;
  localparam int CSR_CH_W = 4;
  localparam int CSR_ON = 5;
  localparam int CSR_SPEED = 6;
  localparam int CSR_EOC = 7;
  localparam logic [7:0] CSR_RESET = 8'h00;
  // ==========================================================================
  // Result layout and codes
  // ==========================================================================
  localparam int RES_BITS = 10;
  localparam int RES_HIGH_LSB = 2;
  localparam logic [9:0] RES_RESET = 10'h000;
  localparam logic [9:0] RES_FULL = 10'h3FF;
  localparam logic [9:0] RES_ZERO = 10'h000;
  // ==========================================================================
  // Channels and timing
  // ==========================================================================
  localparam int NUM_CH = 16;
  localparam int DIV_SLOW = 4;
  localparam int DIV_FAST = 2;
  localparam int SAMPLE_TICKS = 4;
  typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT} sar_state_type;
endpackage

/* File: tb/sar_converter_control_tb_top.sv */
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
module sar_converter_control_tb_top;
  localparam int SC = 1;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic csr_wr = 1'b0;
  logic [7:0] csr_wdata = 8'h00;
  logic result_high_rd = 1'b0;
  logic halt_mode = 1'b0;
  logic comp_in = 1'b1;
  logic [15:0] pin_level = 16'h0000;
  logic [7:0] status, res_h, res_l;
  logic [3:0] chan;
  logic power, cclk, hold;
  logic [9:0] dac_code;
  logic [15:0] port_level;
  int mismatches = 0;
  int total_checks = 0;
  int n;

  always #5 ref_clk = ~ref_clk;

  sar_converter_control #(.SAMPLE_CYC(SC), .CHANNELS(16)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .csr_wr(csr_wr), .csr_wdata(csr_wdata),
    .result_high_rd(result_high_rd), .halt_mode(halt_mode), .comp_in(comp_in),
    .pin_level(pin_level), .converter_control_status(status), .result_high(res_h),
    .result_low(res_l), .channel_select(chan), .converter_power(power),
    .converter_clock(cclk), .sample_hold(hold), .dac_code(dac_code),
    .port_level(port_level)
  );

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic end_sim();
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Checks that a cycle count lies inside the allowed window.
  task automatic chk_win(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] d);
    @(negedge ref_clk);
    csr_wr = 1'b1;
    csr_wdata = d;
    @(negedge ref_clk);
    csr_wr = 1'b0;
  endtask

  task automatic wait_done(output int cnt);
    cnt = 0;
    while (status[7] !== 1'b1 && cnt < 400) begin
      @(negedge ref_clk);
      cnt++;
    end
  endtask

  // Cycles between two rising edges of the converter clock.
  task automatic clk_period(output int cnt);
    int i;
    i = 0;
    while (cclk !== 1'b0 && i < 20) begin @(negedge ref_clk); i++; end
    while (cclk !== 1'b1 && i < 20) begin @(negedge ref_clk); i++; end
    cnt = 0;
    do begin @(negedge ref_clk); cnt++; end while (cclk !== 1'b0 && cnt < 20);
    while (cclk !== 1'b1 && cnt < 20) begin @(negedge ref_clk); cnt++; end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    chk_val({8'h00, status}, {8'h00, sar_pkg::CSR_RESET});
    chk_val({res_h, res_l}, 16'h0000);
    chk_val({15'h0000, power}, 16'h0000);
  endtask

  task automatic t_full();
    comp_in = 1'b1;
    wr(8'h65);
    chk_val({12'h000, chan}, 16'h0005);
    wait_done(n);
    chk_win(n, 21 * 2 - 3, 21 * 2 + 6);
    chk_val({res_h, res_l}, 16'hFF03);
    chk_val({8'h00, status}, 16'h00E5);
    chk_val({15'h0000, power}, 16'h0001);
    result_high_rd = 1'b1;
    @(negedge ref_clk);
    result_high_rd = 1'b0;
    chk_val({15'h0000, status[7]}, 16'h0000);
    wait_done(n);
    chk_win(n, 21 * 2 - 4, 21 * 2 + 2);
  endtask

  task automatic t_zero();
    comp_in = 1'b0;
    wait_done(n);
    wait_done(n);
    wr(8'h65);
    wait_done(n);
    chk_val({res_h, res_l}, 16'h0000);
    wr(8'h65);
    chk_val({15'h0000, status[7]}, 16'h0000);
  endtask

  task automatic t_chan();
    for (int c = 0; c < 16; c++) begin
      wr(8'h60 | 8'(c));
      chk_val({12'h000, chan}, 16'(c));
      chk_val({8'h00, status}, 16'h0060 | 16'(c));
    end
    repeat (30) @(negedge ref_clk);
    wr(8'h63);
    wait_done(n);
    chk_win(n, 21 * 2 - 3, 21 * 2 + 6);
  endtask

  task automatic t_speed();
    clk_period(n);
    chk_win(n, 2, 2);
    wr(8'h23);
    clk_period(n);
    chk_win(n, 4, 4);
    wr(8'h24);
    chk_val({6'h00, dac_code}, 16'h0000);
    @(negedge ref_clk);
    chk_val({15'h0000, hold}, 16'h0001);
    wait_done(n);
    chk_win(n, 21 * 4 - 4, 21 * 4 + 8);
  endtask

  task automatic t_halt();
    wr(8'h63);
    halt_mode = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk_val({14'h0000, power, hold}, 16'h0000);
    chk_val({6'h00, dac_code}, 16'h0000);
    wait_done(n);
    chk_val({15'h0000, status[7]}, 16'h0000);
    halt_mode = 1'b0;
    wait_done(n);
    chk_win(n, 21 * 2 - 3, 21 * 2 + 6);
    wr(8'h03);
    repeat (3) @(negedge ref_clk);
    chk_val({13'h0000, power, cclk, hold}, 16'h0000);
    wait_done(n);
    chk_val({15'h0000, status[7]}, 16'h0000);
  endtask

  task automatic t_pins();
    pin_level = 16'hA5C3;
    repeat (3) @(negedge ref_clk);
    chk_val(port_level, 16'hA5C3);
    pin_level = 16'h5A3C;
    repeat (3) @(negedge ref_clk);
    chk_val(port_level, 16'h5A3C);
  endtask

  initial begin
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    t_reset();
    t_full();
    t_zero();
    t_chan();
    t_speed();
    t_halt();
    t_pins();
    end_sim();
  end

  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
endmodule
